// *** rnc_pkg.sv ***
// Package for the rotate-without-carry datapath slice.
// Assumes a decoder that presents one 16-bit instruction word per cycle.
package rnc_pkg;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam logic [5:0] ROTATE_LEFT_PLAIN_OP  = 6'h11;
  localparam logic [5:0] ROTATE_RIGHT_PLAIN_OP = 6'h10;
  localparam int         OPC_MSB               = 15;
  localparam int         OPC_LSB               = 10;
  localparam int         DEST_BIT              = 9;
  localparam int         BANK_BIT              = 8;
  localparam logic [3:0] ACCESS_BANK           = 4'h0;
  localparam logic [7:0] WREG_RESET            = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RNC_DECODE  = 2'b00,
    RNC_READ    = 2'b01,
    RNC_PROCESS = 2'b10,
    RNC_WRITE   = 2'b11
  } rnc_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        we;
  } rnc_file_wr_t;

  typedef struct packed {
    logic neg;
    logic zero;
    logic we;
  } rnc_flags_t;

endpackage

// *** rnc_rotator.sv ***
// Combinational rotate by one bit and flag generation.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
module rnc_rotator (
  // Operand
  input  wire logic [7:0] operand,
  input  wire logic       left,
  // Result
  output logic      [7:0] result,
  output logic            neg,
  output logic            zero
);

  always_comb begin
    if (left) begin
      result = {operand[6:0], operand[7]};
    end else begin
      result = {operand[0], operand[7:1]};
    end
    neg  = result[7];
    zero = (result == 8'h00);
  end

endmodule

// *** rnc_rotate_no_carry_unit.sv ***
// Rotate-without-carry unit: decode, read, process, write phases.
// Assumes a register file that answers a read combinationally, in the same cycle as rd_en.
`timescale 1ns/1ps

module rnc_rotate_no_carry_unit (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Instruction
  input  wire logic [15:0]           instr,
  input  wire logic                  instr_valid,
  input  wire logic [3:0]            bank_select_value,
  // Register file read
  output logic      [11:0]           rd_addr,
  output logic                       rd_en,
  input  wire logic [7:0]            rd_data,
  // Results
  output rnc_pkg::rnc_file_wr_t      file_wr,
  output logic      [7:0]            wreg,
  output rnc_pkg::rnc_flags_t        flags,
  output logic                       busy
);

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  rnc_pkg::rnc_phase_t   phase_q, phase_d;
  logic                  busy_q, busy_d;
  logic [11:0]           addr_q, addr_d;
  logic                  left_q, left_d;
  logic                  dest_q, dest_d;
  logic                  rd_en_q, rd_en_d;
  logic [7:0]            oper_q, oper_d;
  logic [7:0]            res_q, res_d;
  logic                  neg_q, neg_d;
  logic                  zero_q, zero_d;
  logic [7:0]            wreg_q, wreg_d;
  rnc_pkg::rnc_file_wr_t wr_q, wr_d;
  rnc_pkg::rnc_flags_t   flg_q, flg_d;
  logic [5:0]            opcode;
  logic                  op_left;
  logic                  op_right;
  logic                  hit;
  logic [3:0]            bank;
  logic [7:0]            rot_res;
  logic                  rot_neg;
  logic                  rot_zero;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign opcode   = instr[rnc_pkg::OPC_MSB:rnc_pkg::OPC_LSB];
  assign op_left  = (opcode == rnc_pkg::ROTATE_LEFT_PLAIN_OP);
  assign op_right = (opcode == rnc_pkg::ROTATE_RIGHT_PLAIN_OP);
  assign hit      = instr_valid && (op_left || op_right);
  assign bank     = instr[rnc_pkg::BANK_BIT] ? bank_select_value
                                             : rnc_pkg::ACCESS_BANK;

  // ---------------------------------------------------------------
  // Rotator
  // ---------------------------------------------------------------
  rnc_rotator u_rot (
    .operand (oper_q),
    .left    (left_q),
    .result  (rot_res),
    .neg     (rot_neg),
    .zero    (rot_zero)
  );

  // ---------------------------------------------------------------
  // Phase sequence
  // ---------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      rnc_pkg::RNC_DECODE: begin
        if (hit) begin
          phase_d = rnc_pkg::RNC_READ;
        end
      end
      rnc_pkg::RNC_READ: begin
        phase_d = rnc_pkg::RNC_PROCESS;
      end
      rnc_pkg::RNC_PROCESS: begin
        phase_d = rnc_pkg::RNC_WRITE;
      end
      rnc_pkg::RNC_WRITE: begin
        phase_d = rnc_pkg::RNC_DECODE;
      end
    endcase
    busy_d = (phase_d != rnc_pkg::RNC_DECODE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= rnc_pkg::RNC_DECODE;
      busy_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      busy_q  <= busy_d;
    end
  end

  // ---------------------------------------------------------------
  // Instruction capture
  // ---------------------------------------------------------------
  always_comb begin
    addr_d  = addr_q;
    left_d  = left_q;
    dest_d  = dest_q;
    rd_en_d = 1'b0;
    if ((phase_q == rnc_pkg::RNC_DECODE) && hit) begin
      addr_d  = {bank, instr[7:0]};
      left_d  = op_left;
      dest_d  = instr[rnc_pkg::DEST_BIT];
      rd_en_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q  <= 12'h000;
      left_q  <= 1'b0;
      dest_q  <= 1'b0;
      rd_en_q <= 1'b0;
    end else begin
      addr_q  <= addr_d;
      left_q  <= left_d;
      dest_q  <= dest_d;
      rd_en_q <= rd_en_d;
    end
  end

  // ---------------------------------------------------------------
  // Operand capture
  // ---------------------------------------------------------------
  always_comb begin
    oper_d = oper_q;
    if (phase_q == rnc_pkg::RNC_READ) begin
      oper_d = rd_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oper_q <= 8'h00;
    end else begin
      oper_q <= oper_d;
    end
  end

  // ---------------------------------------------------------------
  // Rotate result
  // ---------------------------------------------------------------
  always_comb begin
    res_d  = res_q;
    neg_d  = neg_q;
    zero_d = zero_q;
    if (phase_q == rnc_pkg::RNC_PROCESS) begin
      res_d  = rot_res;
      neg_d  = rot_neg;
      zero_d = rot_zero;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_q  <= 8'h00;
      neg_q  <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      res_q  <= res_d;
      neg_q  <= neg_d;
      zero_q <= zero_d;
    end
  end

  // ---------------------------------------------------------------
  // Destination write
  // ---------------------------------------------------------------
  always_comb begin
    wreg_d = wreg_q;
    wr_d   = '0;
    flg_d  = '0;
    if (phase_q == rnc_pkg::RNC_WRITE) begin
      if (dest_q) begin
        wr_d.addr = addr_q;
        wr_d.data = res_q;
        wr_d.we   = 1'b1;
      end else begin
        wreg_d = res_q;
      end
      flg_d.neg  = neg_q;
      flg_d.zero = zero_q;
      flg_d.we   = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wreg_q <= rnc_pkg::WREG_RESET;
      wr_q   <= '0;
      flg_q  <= '0;
    end else begin
      wreg_q <= wreg_d;
      wr_q   <= wr_d;
      flg_q  <= flg_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_addr = addr_q;
  assign rd_en   = rd_en_q;
  assign file_wr = wr_q;
  assign wreg    = wreg_q;
  assign flags   = flg_q;
  assign busy    = busy_q;

endmodule

// *** rnc_regfile_model.sv ***
// Register file model answering the unit's reads.
// Assumes the unit samples read data while its read enable stands.
`timescale 1ns/1ps
module rnc_regfile_model (
  // Clock
  input  wire logic                  core_clk,
  // Read and write
  input  wire logic                  rd_en,
  input  wire logic [11:0]           rd_addr,
  input  wire rnc_pkg::rnc_file_wr_t file_wr,
  output logic      [7:0]            rd_data
);
  logic [7:0] mem [4096];
  logic [7:0] junk_q;
  initial begin
    junk_q = 8'h5a;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ {i[11:8], 4'h0};
  end
  // Data while the read stands, else a changing pattern
  assign rd_data = rd_en ? mem[rd_addr] : junk_q;
  always @(posedge core_clk) begin
    junk_q <= ~junk_q;
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  end
endmodule

// *** rnc_unit_sva.sv ***
// Checker on the rotate unit's ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module rnc_unit_chk (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Instruction
  input  wire logic [15:0]           instr,
  input  wire logic                  instr_valid,
  input  wire logic [3:0]            bank_select_value,
  // Register file
  input  wire logic [11:0]           rd_addr,
  input  wire logic                  rd_en,
  input  wire logic [7:0]            rd_data,
  // Results
  input  wire rnc_pkg::rnc_file_wr_t file_wr,
  input  wire logic [7:0]            wreg,
  input  wire rnc_pkg::rnc_flags_t   flags,
  input  wire logic                  busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [11:0] ea_q;
  logic [7:0]  op_q;
  logic        l_q, d_q;
  wire         tk = instr_valid & ~busy & (instr[15:11] == 5'h08);
  wire  [7:0]  r = l_q ? {op_q[6:0], op_q[7]} : {op_q[0], op_q[7:1]};
  always_ff @(posedge core_clk) begin
    if (rd_en) op_q <= rd_data;
    if (tk) begin
      ea_q <= {instr[8] ? bank_select_value : 4'h0, instr[7:0]};
      l_q  <= instr[10];
      d_q  <= instr[9];
    end
  end
  chk_read_addr: assert property (tk |=> rd_en && rd_addr == ea_q)
    else $error("read address wrong");
  chk_write_time: assert property (tk |-> ##4 flags.we)
    else $error("write late");
  chk_busy_span: assert property (tk |=> busy [*3] ##1 !busy)
    else $error("busy span wrong");
  chk_file_dest: assert property (flags.we |-> file_wr.we == d_q)
    else $error("destination wrong");
  chk_wreg_keep: assert property (flags.we && d_q |-> $stable(wreg))
    else $error("wreg changed");
  chk_rot_left: assert property (flags.we && l_q |->
    (d_q ? file_wr.data : wreg) == r)
    else $error("left rotate wrong");
  chk_rot_right: assert property (flags.we && !l_q |->
    (d_q ? file_wr.data : wreg) == r)
    else $error("right rotate wrong");
  chk_flag_value: assert property (flags.we |->
    flags.neg == r[7] && flags.zero == (r == 8'h00))
    else $error("flags wrong");
  chk_rd_single: assert property (rd_en |=> !rd_en)
    else $error("read not a pulse");
  cov_left: cover property (tk && instr[10]);
  cov_right: cover property (tk && !instr[10]);
  cov_wreg: cover property (flags.we && !d_q);
endmodule
bind rnc_rotate_no_carry_unit rnc_unit_chk u_chk (
  .core_clk          (core_clk),
  .rst               (rst),
  .instr             (instr),
  .instr_valid       (instr_valid),
  .bank_select_value (bank_select_value),
  .rd_addr           (rd_addr),
  .rd_en             (rd_en),
  .rd_data           (rd_data),
  .file_wr           (file_wr),
  .wreg              (wreg),
  .flags             (flags),
  .busy              (busy)
);

// *** tb_rotate_no_carry_unit.sv ***
// Testbench for the rotate unit with a register file model.
// Assumes inputs change on the falling clock edge.
`timescale 1ns/1ps
module tb_rotate_no_carry_unit;
  logic                  core_clk, rst, instr_valid, rd_en;
  logic [15:0]           instr;
  logic [3:0]            bank_select_value;
  logic [11:0]           rd_addr;
  logic [7:0]            rd_data, wreg;
  rnc_pkg::rnc_file_wr_t file_wr;
  rnc_pkg::rnc_flags_t   flags;
  logic                  busy;
  int                    failures, checks_done, cyc;
  rnc_rotate_no_carry_unit DUT (
    .core_clk          (core_clk),
    .rst               (rst),
    .instr             (instr),
    .instr_valid       (instr_valid),
    .bank_select_value (bank_select_value),
    .rd_addr           (rd_addr),
    .rd_en             (rd_en),
    .rd_data           (rd_data),
    .file_wr           (file_wr),
    .wreg              (wreg),
    .flags             (flags),
    .busy              (busy)
  );
  rnc_regfile_model pm (.core_clk(core_clk), .rd_en(rd_en),
    .rd_addr(rd_addr), .file_wr(file_wr), .rd_data(rd_data));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rot(logic l, logic d, logic a, logic [7:0] f, logic [3:0] b);
    logic [7:0] v, e, w;
    logic [3:0] k;
    @(negedge core_clk);
    k = a ? b : 4'h0;
    v = pm.mem[{k, f}];
    e = l ? {v[6:0], v[7]} : {v[0], v[7:1]};
    w = wreg;
    instr = {5'h08, l, d, a, f};
    bank_select_value = b;
    instr_valid = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("we", {7'h00, d}, {7'h00, file_wr.we});
    chk("res", e, d ? file_wr.data : wreg);
    chk("wkeep", d ? w : e, wreg);
    chk("alo", d ? f : 8'h00, file_wr.addr[7:0]);
    chk("ahi", {4'h0, d ? k : 4'h0}, {4'h0, file_wr.addr[11:8]});
    chk("fwe", 8'h01, {7'h00, flags.we});
    chk("neg", {7'h00, e[7]}, {7'h00, flags.neg});
    chk("zero", {7'h00, e == 8'h00}, {7'h00, flags.zero});
    instr_valid = 1'b0;
  endtask
  task automatic t_left;
    rot(1'b1, 1'b0, 1'b0, 8'h80, 4'h5);
    rot(1'b1, 1'b1, 1'b1, 8'h33, 4'h2);
    rot(1'b1, 1'b1, 1'b1, 8'h33, 4'h2);
    $display("test left done");
  endtask
  task automatic t_right;
    rot(1'b0, 1'b1, 1'b0, 8'h01, 4'h9);
    rot(1'b0, 1'b0, 1'b1, 8'hd7, 4'hf);
    rot(1'b1, 1'b0, 1'b0, 8'h00, 4'h3);
    $display("test right done");
  endtask
  task automatic t_refuse;
    @(negedge core_clk);
    instr = 16'h3555;
    instr_valid = 1'b1;
    repeat (2) begin
      @(negedge core_clk);
      chk("rd_en", 8'h00, {7'h00, rd_en});
      chk("busy", 8'h00, {7'h00, busy});
    end
    instr_valid = 1'b0;
    $display("test refuse done");
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    instr = 16'h0000;
    instr_valid = 1'b0;
    bank_select_value = 4'h0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_left();
    t_right();
    t_refuse();
    results();
  end
endmodule
